// ### jrl_rx_lane_xbar.sv
// Receive lane crossbar, multiframe delay, release buffer and latency readback
`include "jrl_regs.svh"

module jrl_rx_lane_xbar #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   input  wire logic [11:0]        regAddr,
   input  wire logic [7:0]         regWdata,
   output logic      [7:0]         regRdata,
   input  wire logic [3:0][W-1:0]  physicalSerialInput,
   input  wire logic [3:0]         physicalValid,
   input  wire logic [3:0]         physicalBoundary,
   input  wire logic               framePulse,
   input  wire logic               lmfcPulse,
   output logic                    receiveMultiframeClock,
   output logic      [3:0][W-1:0]  laneData,
   output logic      [3:0]         laneValid
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   jrl_pkg::jrl_state_t q;         // Registered state
   jrl_pkg::jrl_state_t d;         // Next state
   logic [3:0][W-1:0]   xbarData;  // Crossbar data per logical lane
   logic [3:0]          xbarBound; // Crossbar boundary per logical lane
   logic [3:0]          fullFlags; // Per-lane full flags
   logic                unitTick;  // One unit of multiframe delay
   logic [3:0]          seenBase;  // Seen mask before this cycle
   logic [3:0]          seenNew;   // Seen mask including this cycle
   logic [4:0]          latNext;   // Latency counter next value

   jrl_lane_if #(.W(W)) lb [3:0] ();

   // ***********************************************************
   // Crossbar and lane buffers
   // ***********************************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gLane
         // Source codes above three select no lane and give silence
         always_comb begin
            if (q.laneSrc[g][2] == 1'b0) begin
               xbarData[g]  = physicalSerialInput[q.laneSrc[g][1:0]];
               xbarBound[g] = physicalBoundary[q.laneSrc[g][1:0]];
               lb[g].wrValid = physicalValid[q.laneSrc[g][1:0]];
            end else begin
               xbarData[g]  = '0;
               xbarBound[g] = 1'b0;
               lb[g].wrValid = 1'b0;
            end
         end
         assign lb[g].wrData = xbarData[g];
         assign lb[g].rdEn   = q.released;
         assign laneData[g]  = lb[g].rdData;
         assign laneValid[g] = lb[g].rdValid;
         assign fullFlags[g] = lb[g].full;

         jrl_lane_buffer #(.W(W), .DEPTH(DEPTH), .AW($clog2(DEPTH))) uBuf (
            .clock (clock),
            .rst   (rst),
            .lane  (lb[g])
         );
      end
   endgenerate

   // ***********************************************************
   // Next-state logic
   // ***********************************************************
   always_comb begin
      d        = q;
      d.rxMf   = 1'b0;
      // Subclass 1 counts frame clocks, subclass 0 lane-word cycles
      unitTick = (q.subclass == `JRL_SUBCLASS_1) ? framePulse : 1'b1;
      // Multiframe delay countdown; a new local pulse restarts it
      if (lmfcPulse) begin
         d.delayArmed = 1'b1;
         d.delayCnt   = q.mfDelay;
      end else if (q.delayArmed) begin
         if (q.delayCnt == 5'h00) begin
            d.rxMf       = 1'b1;
            d.delayArmed = 1'b0;
         end else if (unitTick) begin
            d.delayCnt = q.delayCnt - 5'h01;
         end
      end
      // Latency: cycles from receive multiframe clock to last lane boundary
      seenBase = q.rxMf ? 4'h0 : q.seen;
      seenNew  = seenBase | xbarBound;
      if (q.rxMf) begin
         latNext = 5'h00;
      end else if (q.latCnt == 5'h1f) begin
         latNext = q.latCnt; // Saturate rather than wrap
      end else begin
         latNext = q.latCnt + 5'h01;
      end
      d.latCnt = latNext;
      d.seen   = seenNew;
      if (seenNew == 4'hf && seenBase != 4'hf) begin
         d.latency = latNext;
      end
      // Release countdown starts at the first receive multiframe clock
      if (q.rxMf && !q.released && !q.relArmed) begin
         d.relArmed = 1'b1;
         d.relCnt   = q.relOffset;
      end else if (q.relArmed) begin
         if (q.relCnt == 5'h00) begin
            d.released = 1'b1;
            d.relArmed = 1'b0;
         end else begin
            d.relCnt = q.relCnt - 5'h01;
         end
      end
      // Register writes; offsets above ten are the host's to avoid
      if (regWrite) begin
         case (regAddr)
            `JRL_ADDR_SUBCLASS: begin
               // Only the two defined encodings are taken
               if (regWdata[2:0] == `JRL_SUBCLASS_0 || regWdata[2:0] == `JRL_SUBCLASS_1) begin
                  d.subclass = regWdata[2:0];
               end
            end
            `JRL_ADDR_MFDELAY: begin
               d.mfDelay = regWdata[4:0];
            end
            `JRL_ADDR_RELEASE: begin
               // New offset re-arms alignment at the next multiframe
               d.relOffset = regWdata[4:0];
               d.released  = 1'b0;
               d.relArmed  = 1'b0;
            end
            `JRL_ADDR_MAPLO: begin
               d.laneSrc[0] = regWdata[`JRL_SRC_EVEN_LSB +: 3];
               d.laneSrc[1] = regWdata[`JRL_SRC_ODD_LSB +: 3];
            end
            `JRL_ADDR_MAPHI: begin
               d.laneSrc[2] = regWdata[`JRL_SRC_EVEN_LSB +: 3];
               d.laneSrc[3] = regWdata[`JRL_SRC_ODD_LSB +: 3];
            end
            default: begin
               // Read-only or unmapped: write ignored
            end
         endcase
      end
      // Register reads; reserved and unmapped bits read zero
      if (regRead) begin
         case (regAddr)
            `JRL_ADDR_SUBCLASS: d.rdData = {5'h00, q.subclass};
            `JRL_ADDR_LATENCY:  d.rdData = {3'h0, q.latency};
            `JRL_ADDR_MFDELAY:  d.rdData = {3'h0, q.mfDelay};
            `JRL_ADDR_RELEASE:  d.rdData = {3'h0, q.relOffset};
            `JRL_ADDR_MAPLO:    d.rdData = {2'h0, q.laneSrc[1], q.laneSrc[0]};
            `JRL_ADDR_MAPHI:    d.rdData = {2'h0, q.laneSrc[3], q.laneSrc[2]};
            `JRL_ADDR_FULL:     d.rdData = {4'h0, fullFlags};
            default:            d.rdData = 8'h00;
         endcase
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         q            <= '0;
         q.subclass   <= `JRL_RST_SUBCLASS;
         q.mfDelay    <= `JRL_RST_MFDELAY;
         q.relOffset  <= `JRL_RST_RELEASE;
         // Each pair loads as its map register reads back, odd lane above
         q.laneSrc[1:0] <= `JRL_RST_MAPLO;
         q.laneSrc[3:2] <= `JRL_RST_MAPHI;
      end else begin
         q <= d;
      end
   end

   assign regRdata               = q.rdData;
   assign receiveMultiframeClock = q.rxMf;

   // ***********************************************************
   // Checks
   // ***********************************************************
   a_latency_capture: assert property (@(posedge clock) disable iff (rst)
      (!q.rxMf && q.seen != 4'hf && (q.seen | xbarBound) == 4'hf && q.latCnt != 5'h1f)
      |=> q.latency == $past(q.latCnt) + 5'h01)
      else $error("latency not captured at last boundary");
   a_delay_zero: assert property (@(posedge clock) disable iff (rst)
      (lmfcPulse && q.mfDelay == 5'h00) ##1 !lmfcPulse |=> q.rxMf)
      else $error("zero delay did not fire after two cycles");
   a_delay_cycles: assert property (@(posedge clock) disable iff (rst)
      (lmfcPulse && q.subclass == `JRL_SUBCLASS_0 && q.mfDelay == 5'h02) ##1 (!lmfcPulse)[*3] |=> q.rxMf)
      else $error("subclass 0 delay of two missed");
   a_delay_frames: assert property (@(posedge clock) disable iff (rst)
      (lmfcPulse && q.subclass == `JRL_SUBCLASS_1 && q.mfDelay == 5'h01) ##1 (!lmfcPulse && !framePulse)[*3]
      |=> !q.rxMf)
      else $error("subclass 1 delay advanced without frame clock");
   a_release_offset: assert property (@(posedge clock) disable iff (rst)
      (q.rxMf && !q.released && !q.relArmed && q.relOffset == 5'h01)
      ##1 (!(regWrite && regAddr == `JRL_ADDR_RELEASE))[*2] |=> q.released)
      else $error("release not reached after offset");
   a_xbar_route: assert property (@(posedge clock) disable iff (rst)
      (regWrite && regAddr == `JRL_ADDR_MAPLO && regWdata[2:0] == 3'h2) |=> xbarData[0] == physicalSerialInput[2])
      else $error("lane 0 not routed from selected source");
   a_xbar_reset: assert property (@(posedge clock)
      rst |=> (xbarData[1] == physicalSerialInput[1] && xbarData[3] == physicalSerialInput[3]))
      else $error("crossbar not straight after reset");
   a_subclass_bad: assert property (@(posedge clock) disable iff (rst)
      (regWrite && regAddr == `JRL_ADDR_SUBCLASS && regWdata[2:1] != 2'h0) |=> $stable(q.subclass))
      else $error("undefined subclass encoding accepted");
   a_release_hold: assert property (@(posedge clock) disable iff (rst)
      (q.released && !(regWrite && regAddr == `JRL_ADDR_RELEASE)) |=> q.released)
      else $error("release dropped without offset write");
   a_rxmf_single: assert property (@(posedge clock) disable iff (rst)
      q.rxMf |=> !q.rxMf)
      else $error("receive multiframe clock longer than one cycle");
   a_xbar_silent: assert property (@(posedge clock) disable iff (rst)
      (regWrite && regAddr == `JRL_ADDR_MAPHI && regWdata[2]) |=> (!xbarBound[2] && xbarData[2] == '0))
      else $error("unused source code still routed a lane");

endmodule : jrl_rx_lane_xbar

// ### jrl_regs.svh
// Register map, field positions and reset values of the receive lane crossbar and latency block
// Notes on behaviour
// - Read back measured latency in lane-word cycles
// - Delay receive multiframe clock by programmable amount
// - Each logical lane selects its physical source lane
// - Crossbar resets to straight-through lane mapping
// - Per-lane full flag shows FIFO full condition
`ifndef JRL_REGS_SVH
`define JRL_REGS_SVH

// ***********************************************************
// Register offsets
// ***********************************************************
`define JRL_ADDR_SUBCLASS  12'h301
`define JRL_ADDR_LATENCY   12'h302
`define JRL_ADDR_MFDELAY   12'h304
`define JRL_ADDR_RELEASE   12'h306
`define JRL_ADDR_MAPLO     12'h308
`define JRL_ADDR_MAPHI     12'h309
`define JRL_ADDR_FULL      12'h30c

// ***********************************************************
// Field positions and encodings
// ***********************************************************
`define JRL_SRC_EVEN_LSB   0
`define JRL_SRC_ODD_LSB    3
`define JRL_SUBCLASS_0     3'h0
`define JRL_SUBCLASS_1     3'h1

// ***********************************************************
// Reset values
// ***********************************************************
`define JRL_RST_SUBCLASS   3'h1
`define JRL_RST_MFDELAY    5'h00
`define JRL_RST_RELEASE    5'h06
`define JRL_RST_MAPLO      6'h08
`define JRL_RST_MAPHI      6'h1a

`endif

// ### jrl_pkg.sv
// Types shared by the receive lane crossbar and latency block
package jrl_pkg;

   // ***********************************************************
   // Top-level state
   // ***********************************************************
   typedef struct packed {
      logic [2:0]       subclass;    // Link subclass select
      logic [4:0]       mfDelay;     // Receive multiframe delay setting
      logic [4:0]       relOffset;   // Buffer release offset setting
      logic [3:0][2:0]  laneSrc;     // Source physical lane per logical lane
      logic [4:0]       delayCnt;    // Remaining delay units
      logic             delayArmed;  // Delay countdown running
      logic             rxMf;        // Receive multiframe clock pulse
      logic [4:0]       latCnt;      // Cycles since receive multiframe clock
      logic [3:0]       seen;        // Lanes whose boundary has arrived
      logic [4:0]       latency;     // Measured link latency
      logic [4:0]       relCnt;      // Remaining release cycles
      logic             relArmed;    // Release countdown running
      logic             released;    // Buffers are being read out
      logic [7:0]       rdData;      // Register read data
   } jrl_state_t;

endpackage : jrl_pkg

// ### jrl_lane_if.sv
// Carrier between the top block and one logical lane delay buffer
interface jrl_lane_if #(
   parameter int W = 32
);
   logic [W-1:0] wrData;   // Crossbar output into the buffer
   logic         wrValid;  // Word present
   logic         rdEn;     // Release readout
   logic [W-1:0] rdData;   // Released word
   logic         rdValid;  // Released word valid
   logic         full;     // Buffer full
   logic         empty;    // Buffer empty

   modport buffer (input wrData, input wrValid, input rdEn,
                   output rdData, output rdValid, output full, output empty);
   modport ctrl   (output wrData, output wrValid, output rdEn,
                   input rdData, input rdValid, input full, input empty);
endinterface : jrl_lane_if

// ### jrl_lane_buffer.sv
// Delay buffer of one logical lane
module jrl_lane_buffer #(
   parameter int W     = 32,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input wire logic   clock,
   input wire logic   rst,
   jrl_lane_if.buffer lane
);

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;      // Storage words
      logic [AW-1:0]           wp;       // Write pointer
      logic [AW-1:0]           rp;       // Read pointer
      logic [AW:0]             cnt;      // Fill level
      logic [W-1:0]            out;      // Output word
      logic                    outValid; // Output word valid
   } jrl_buf_t;

   jrl_buf_t q;  // Registered state
   jrl_buf_t d;  // Next state
   logic     wr; // Accepted write
   logic     rd; // Accepted read

   // Words arriving while full are lost; the full flag tells software so
   always_comb begin
      d          = q;
      d.outValid = 1'b0;
      wr         = lane.wrValid && (q.cnt != (AW+1)'(DEPTH));
      rd         = lane.rdEn && (q.cnt != '0);
      if (wr) begin
         d.mem[q.wp] = lane.wrData;
         d.wp        = q.wp + 1'b1;
      end
      if (rd) begin
         d.out      = q.mem[q.rp];
         d.outValid = 1'b1;
         d.rp       = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
   end

   // Register the state
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lane.rdData  = q.out;
   assign lane.rdValid = q.outValid;
   assign lane.full    = (q.cnt == (AW+1)'(DEPTH));
   assign lane.empty   = (q.cnt == '0);

   a_full_holds: assert property (@(posedge clock) disable iff (rst)
      (lane.full && !lane.rdEn) |=> lane.full)
      else $error("full flag dropped without a read");
   a_full_rises: assert property (@(posedge clock) disable iff (rst)
      (q.cnt == (AW+1)'(DEPTH-1) && lane.wrValid && !lane.rdEn) |=> lane.full)
      else $error("full flag missed last free word");
   a_empty_read: assert property (@(posedge clock) disable iff (rst)
      (lane.empty && lane.rdEn) |=> !lane.rdValid)
      else $error("word released from an empty buffer");

endmodule : jrl_lane_buffer

// ### jrl_tx_model.sv
// Transmitter model that feeds the four physical lanes of the receive block
module jrl_tx_model #(
   parameter int W = 32
) (
   input  wire logic              clock,
   output logic      [3:0][W-1:0] physicalSerialInput,
   output logic      [3:0]        physicalValid,
   output logic      [3:0]        physicalBoundary
);
   timeunit 1ns;
   timeprecision 1ns;

   // ***********************************************************
   // Line drivers, changed only at the falling edge
   // ***********************************************************
   // Lines start quiet so the receiver sees no word before a burst
   initial begin
      physicalSerialInput = '0;
      physicalValid       = '0;
      physicalBoundary    = '0;
   end

   // Burst of words tagged with lane and sequence number
   task send_words(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         for (int l = 0; l < 4; l++) begin
            physicalSerialInput[l] = {l[7:0], i[23:0]};
         end
         physicalValid = 4'hf;
      end
      @(negedge clock);
      physicalValid = 4'h0;
      // Idle data inverted so a stale word can never pass as valid
      physicalSerialInput = ~physicalSerialInput;
   endtask : send_words

   // One boundary pulse per physical lane, gap cycles apart
   task mark_lanes(input int gap);
      for (int l = 0; l < 4; l++) begin
         repeat (gap) @(negedge clock);
         physicalBoundary = 4'h1 << l;
      end
      @(negedge clock);
      physicalBoundary = 4'h0;
   endtask : mark_lanes
endmodule : jrl_tx_model

// ### testbench.sv
// Self-checking testbench of the receive lane crossbar and latency block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   // ***********************************************************
   // Signals and scoreboard
   // ***********************************************************
   logic              clock      = 1'b0;  // Lane-word clock
   logic              rst        = 1'b1;  // Synchronous reset
   logic              regWrite   = 1'b0;  // Write strobe
   logic              regRead    = 1'b0;  // Read strobe
   logic [11:0]       regAddr    = '0;    // Register address
   logic [7:0]        regWdata   = '0;    // Write data
   logic [7:0]        regRdata;           // Read data
   logic [3:0][31:0]  physicalSerialInput;
   logic [3:0]        physicalValid;
   logic [3:0]        physicalBoundary;
   logic              framePulse = 1'b0;  // Frame tick
   logic              lmfcPulse  = 1'b0;  // Local multiframe tick
   logic              receiveMultiframeClock;
   logic [3:0][31:0]  laneData;
   logic [3:0]        laneValid;
   logic              rdPend     = 1'b0;  // Read answer due
   logic [7:0]        frameCnt   = '0;    // Frame tick divider
   logic [7:0]        regQ[$];            // Expected read data
   logic [31:0]       laneQ[4][$];        // Expected released words
   int                perm[4];            // Physical source per logical lane
   int                num_errors = 0;
   int                checked    = 0;

   always #20 clock = ~clock;

   // Frame tick every fourth cycle
   always @(negedge clock) begin
      frameCnt   <= frameCnt + 8'h01;
      framePulse <= (frameCnt[1:0] == 2'h0);
   end

   // Small buffer depth so a short burst reaches full
   jrl_rx_lane_xbar #(.W(32), .DEPTH(4)) i_dut (
      .clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .physicalSerialInput(physicalSerialInput),
      .physicalValid(physicalValid), .physicalBoundary(physicalBoundary), .framePulse(framePulse),
      .lmfcPulse(lmfcPulse), .receiveMultiframeClock(receiveMultiframeClock),
      .laneData(laneData), .laneValid(laneValid));

   jrl_tx_model #(.W(32)) i_tx (
      .clock(clock), .physicalSerialInput(physicalSerialInput),
      .physicalValid(physicalValid), .physicalBoundary(physicalBoundary));

   // ***********************************************************
   // Tasks
   // ***********************************************************
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task results;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // One-cycle write strobe
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clock);
      regWrite = 1'b1;
      regAddr  = a;
      regWdata = d;
      @(negedge clock);
      regWrite = 1'b0;
   endtask : wr

   // Read strobe; the answer is judged by the monitor a cycle later
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge clock);
      regQ.push_back(e);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clock);
      regRead = 1'b0;
   endtask : rd

   // Local tick, then count cycles up to the receive tick
   task mf_pulse(input int lo, input int hi);
      int n;
      @(negedge clock);
      lmfcPulse = 1'b1;
      @(negedge clock);
      lmfcPulse = 1'b0;
      n = 1;
      while (receiveMultiframeClock !== 1'b1 && n < 80) begin
         @(negedge clock);
         n++;
      end
      check("rxMfDelayInRange", 32'(n >= lo && n <= hi), 32'h1);
      if (n >= 80) begin
         results();
      end
   endtask : mf_pulse

   // ***********************************************************
   // Monitor: oldest note against each result
   // ***********************************************************
   always @(posedge clock) begin
      rdPend <= regRead && !rst;
   end

   always @(negedge clock) begin
      if (rdPend === 1'b1) begin
         check("regRdata", 32'(regRdata), 32'(regQ.pop_front()));
      end
      for (int l = 0; l < 4; l++) begin
         if (laneValid[l] === 1'b1) begin
            if (laneQ[l].size() == 0) begin
               check("laneValidSpare", 32'h1, 32'h0);
            end else begin
               check("laneData", laneData[l], laneQ[l].pop_front());
            end
         end
      end
   end

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      int d, r, gap, n, t;
      logic [7:0] rv;
      void'($urandom(45));
      repeat (5) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      // Reset values, then an unmapped address
      rd(12'h301, 8'h01);
      rd(12'h302, 8'h00);
      rd(12'h304, 8'h00);
      rd(12'h306, 8'h06);
      rd(12'h308, 8'h08);
      rd(12'h309, 8'h1a);
      rd(12'h30c, 8'h00);
      rd(12'h300, 8'h00);
      // Random fields, reserved bits read back as zero
      rv = 8'($urandom);
      wr(12'h304, rv);
      rd(12'h304, {3'h0, rv[4:0]});
      // Lane 2 code forced above three so the silent route is exercised
      rv = 8'($urandom) | 8'h04;
      wr(12'h309, rv);
      rd(12'h309, {2'h0, rv[5:0]});
      // Read-only places and an illegal subclass code are ignored
      wr(12'h302, 8'hff);
      rd(12'h302, 8'h00);
      wr(12'h30c, 8'hff);
      rd(12'h30c, 8'h00);
      wr(12'h301, 8'h02);
      rd(12'h301, 8'h01);
      // Subclass 1 counts frame ticks, so the wait is near four cycles a unit
      d = $urandom_range(4, 1);
      wr(12'h304, 8'(d));
      mf_pulse(4 * d - 3, 4 * d + 4);
      // Subclass 0 counts lane-word cycles: zero, random, two and largest delay
      wr(12'h301, 8'h00);
      rd(12'h301, 8'h00);
      // Offset of one re-arms release so the first pulse below times it
      wr(12'h306, 8'h01);
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 0 : (k == 1) ? $urandom_range(30, 1) : (k == 2) ? 2 : 31;
         wr(12'h304, 8'(d));
         mf_pulse(d + 2, d + 2);
      end
      // Random lane permutation through the crossbar
      perm = '{0, 1, 2, 3};
      for (int k = 3; k > 0; k--) begin
         t = $urandom_range(k, 0);
         n = perm[k];
         perm[k] = perm[t];
         perm[t] = n;
      end
      wr(12'h304, 8'h00);
      wr(12'h308, 8'({perm[1][2:0], perm[0][2:0]}));
      wr(12'h309, 8'({perm[3][2:0], perm[2][2:0]}));
      r = $urandom_range(10, 0);
      wr(12'h306, 8'(r));
      // Five words into four-deep buffers: the fifth is lost
      i_tx.send_words(5);
      rd(12'h30c, 8'h0f);
      for (int l = 0; l < 4; l++) begin
         for (int i = 0; i < 4; i++) begin
            laneQ[l].push_back({perm[l][7:0], i[23:0]});
         end
      end
      mf_pulse(2, 2);
      gap = $urandom_range(5, 1);
      n = 0;
      fork
         i_tx.mark_lanes(gap);
         while (laneValid === 4'h0 && n < 40) begin
            @(negedge clock);
            n++;
         end
      join
      check("releaseCycle", 32'(n), 32'(r + 3));
      if (n >= 40) begin
         results();
      end
      repeat (20) @(negedge clock);
      rd(12'h302, 8'(4 * gap));
      rd(12'h30c, 8'h00);
      for (int l = 0; l < 4; l++) begin
         check("laneQueueLeft", 32'(laneQ[l].size()), 32'h0);
      end
      repeat (2) @(negedge clock);
      results();
   end
endmodule : testbench
